// [rtl/i2c_arb_params.svh]
// Constants for the multi-master I2C arbitration block
`ifndef I2C_ARB_PARAMS_SVH
`define I2C_ARB_PARAMS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h1
`define ADDR_BUF 4'h2
`define ADDR_RELOAD 4'h3
`define CTRL_EN 0
`define CTRL_SEN 1
`define CTRL_RSEN 2
`define CTRL_PEN 3
`define CTRL_ACKEN 4
`define CTRL_ACKDT 5
`define CTRL_IE 6
`define STAT_BF 0
`define STAT_START 1
`define STAT_STOP 2
`define STAT_WRITE_COLLISION_FLAG 3
`define STAT_BCOL 4
`define STAT_IF 5
`define STAT_ACKSTAT 6
`define STAT_BUSY 7
`define RELOAD_RST 8'h4F
`endif

// [rtl/i2c_arb_pkg.sv]
// Types for the multi-master I2C arbitration block
package i2c_arb_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_S_WAIT, ST_S_HOLD, ST_RS_LOW, ST_RS_SCLH, ST_RS_WAIT,
        ST_RS_HOLD, ST_TX_LOW, ST_TX_HIGH, ST_ACK_LOW, ST_ACK_HIGH,
        ST_P_LOW, ST_P_HIGH, ST_P_DONE
    } phase_t;
    typedef struct packed {
        logic [6:0] ctrl;
        logic [7:0] reload;
        logic [7:0] buffer;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic [7:0] baud_generator;
        phase_t phase;
        logic bf;
        logic start_seen;
        logic stop_seen;
        logic write_collision_flag;
        logic bcol;
        logic irq_flag;
        logic ackstat;
        logic sda_drive_low;
        logic scl_drive_low;
        logic [1:0] sda_sync;
        logic [1:0] scl_sync;
        logic sda_prev;
        logic scl_prev;
        logic [7:0] rd_data;
        logic wake;
    } state_t;
endpackage : i2c_arb_pkg

// [rtl/i2c_master_bus_arbitration.sv]
// Multi-master I2C master with bus collision and arbitration logic
`timescale 1ns/1ps
`include "i2c_arb_params.svh"
module i2c_master_bus_arbitration (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic slave_event,
    output logic wake_req,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n
);
    // All state in one packed register image
    i2c_arb_pkg::state_t s_r;
    i2c_arb_pkg::state_t s_nxt;

    // Sequence enables occupy the engine; read from control image
    function automatic logic seq_busy(input logic [6:0] c);
        seq_busy = c[`CTRL_SEN] | c[`CTRL_RSEN] | c[`CTRL_PEN] | c[`CTRL_ACKEN];
    endfunction : seq_busy

    // Load generator from reload value; values below 3 are unsupported
    function automatic logic [7:0] brg_load(input logic [7:0] r);
        brg_load = r;
    endfunction : brg_load

    // Synchronised pin levels and bus events
    // Start and Stop are seen only with SCL high on both samples
    logic sda_s;
    logic scl_s;
    logic brg_zero;
    logic stop_cond;
    logic start_cond;
    assign sda_s = s_r.sda_sync[1];
    assign scl_s = s_r.scl_sync[1];
    assign brg_zero = (s_r.baud_generator == 8'h00);
    assign stop_cond = scl_s & s_r.scl_prev & sda_s & ~s_r.sda_prev;
    assign start_cond = scl_s & s_r.scl_prev & ~sda_s & s_r.sda_prev;

    // Whole next state in one place; collision handling overrides phases
    always_comb begin
        logic coll;
        logic en;
        coll = 1'b0;
        s_nxt = s_r;
        en = s_r.ctrl[`CTRL_EN];
        // Two-flop synchronisers; only the second stage feeds logic
        s_nxt.sda_sync = {s_r.sda_sync[0], sda_in};
        s_nxt.scl_sync = {s_r.scl_sync[0], scl_in};
        s_nxt.sda_prev = sda_s;
        s_nxt.scl_prev = scl_s;
        s_nxt.wake = 1'b0;
        // Generator counts down and parks at zero
        if (!brg_zero) begin
            s_nxt.baud_generator = s_r.baud_generator - 8'h01;
        end
        // Bus watching runs while the port is enabled, even after a lost arbitration
        if (start_cond) begin
            s_nxt.start_seen = 1'b1;
            s_nxt.stop_seen = 1'b0;
        end
        if (stop_cond) begin
            s_nxt.stop_seen = 1'b1;
            s_nxt.start_seen = 1'b0;
            if (s_r.start_seen && s_r.ctrl[`CTRL_IE]) begin
                s_nxt.irq_flag = 1'b1;
            end
            if (s_r.bcol) begin
                s_nxt.irq_flag = 1'b1;
            end
        end
        // Sleeping slave events wake the core only when interrupts are enabled
        if (sleep_mode && slave_event && s_r.ctrl[`CTRL_IE]) begin
            s_nxt.wake = 1'b1;
        end
        case (s_r.phase)
            // Idle: sequence enables take priority over a loaded buffer
            // Start is refused at once if either line is already low
            i2c_arb_pkg::ST_IDLE: begin
                if (s_r.ctrl[`CTRL_SEN]) begin
                    if (!sda_s || !scl_s) begin
                        coll = 1'b1;
                    end else begin
                        s_nxt.baud_generator = brg_load(s_r.reload);
                        s_nxt.phase = i2c_arb_pkg::ST_S_WAIT;
                    end
                end else if (s_r.ctrl[`CTRL_RSEN]) begin
                    s_nxt.sda_drive_low = 1'b0;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_RS_LOW;
                end else if (s_r.ctrl[`CTRL_PEN]) begin
                    s_nxt.sda_drive_low = 1'b1;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_P_LOW;
                end else if (s_r.ctrl[`CTRL_ACKEN]) begin
                    s_nxt.scl_drive_low = 1'b1;
                    s_nxt.sda_drive_low = ~s_r.ctrl[`CTRL_ACKDT];
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_ACK_LOW;
                end else if (s_r.bf) begin
                    s_nxt.scl_drive_low = 1'b1;
                    s_nxt.bit_cnt = 4'h0;
                    s_nxt.sda_drive_low = ~s_r.shift[7];
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_TX_LOW;
                end
            end
            // Start count with both lines high
            i2c_arb_pkg::ST_S_WAIT: begin
                if (!sda_s) begin
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.sda_drive_low = 1'b1;
                    s_nxt.phase = i2c_arb_pkg::ST_S_HOLD;
                end else if (!scl_s) begin
                    coll = 1'b1;
                end else if (brg_zero) begin
                    s_nxt.sda_drive_low = 1'b1;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_S_HOLD;
                end
            end
            // SDA held low for one count, then SCL follows
            i2c_arb_pkg::ST_S_HOLD: begin
                // SCL low here is another master's Start, not a collision
                if (brg_zero) begin
                    s_nxt.scl_drive_low = 1'b1;
                    s_nxt.ctrl[`CTRL_SEN] = 1'b0;
                    s_nxt.irq_flag = 1'b1;
                    s_nxt.phase = i2c_arb_pkg::ST_IDLE;
                end
            end
            // Restart: SDA released, SCL kept low for one count
            // so that SDA can settle high before the clock rises
            i2c_arb_pkg::ST_RS_LOW: begin
                if (brg_zero) begin
                    s_nxt.scl_drive_low = 1'b0;
                    s_nxt.phase = i2c_arb_pkg::ST_RS_SCLH;
                end
            end
            // SCL released; sample SDA once it really reads high
            i2c_arb_pkg::ST_RS_SCLH: begin
                // Clock stretching: wait for SCL really high
                if (scl_s) begin
                    if (!sda_s) begin
                        coll = 1'b1;
                    end else begin
                        s_nxt.baud_generator = brg_load(s_r.reload);
                        s_nxt.phase = i2c_arb_pkg::ST_RS_WAIT;
                    end
                end
            end
            // Restart count with both lines high; an early SDA fall
            // from another master ends the count without a collision
            i2c_arb_pkg::ST_RS_WAIT: begin
                if (!scl_s) begin
                    coll = 1'b1;
                end else if (!sda_s) begin
                    s_nxt.sda_drive_low = 1'b1;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_RS_HOLD;
                end else if (brg_zero) begin
                    s_nxt.sda_drive_low = 1'b1;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_RS_HOLD;
                end
            end
            // SCL pulled low at count end whatever its level
            i2c_arb_pkg::ST_RS_HOLD: begin
                if (brg_zero) begin
                    s_nxt.scl_drive_low = 1'b1;
                    s_nxt.ctrl[`CTRL_RSEN] = 1'b0;
                    s_nxt.irq_flag = 1'b1;
                    s_nxt.phase = i2c_arb_pkg::ST_IDLE;
                end
            end
            // Low half of a data or acknowledge clock
            // Data changes only while SCL is held low
            i2c_arb_pkg::ST_TX_LOW, i2c_arb_pkg::ST_ACK_LOW: begin
                if (brg_zero) begin
                    s_nxt.scl_drive_low = 1'b0;
                    s_nxt.phase = (s_r.phase == i2c_arb_pkg::ST_TX_LOW) ?
                        i2c_arb_pkg::ST_TX_HIGH : i2c_arb_pkg::ST_ACK_HIGH;
                end
            end
            // High half: a released SDA read low means lost arbitration
            // The ninth clock of a sent byte belongs to the slave's answer
            i2c_arb_pkg::ST_TX_HIGH, i2c_arb_pkg::ST_ACK_HIGH: begin
                if (!scl_s) begin
                    s_nxt.baud_generator = brg_load(s_r.reload); // Held low by a stretcher
                end else if (!s_r.sda_drive_low && !sda_s
                             && (s_r.bit_cnt != 4'h8
                                 || s_r.phase == i2c_arb_pkg::ST_ACK_HIGH)) begin
                    coll = 1'b1;
                end else if (brg_zero) begin
                    s_nxt.scl_drive_low = 1'b1;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    if (s_r.phase == i2c_arb_pkg::ST_ACK_HIGH) begin
                        s_nxt.ctrl[`CTRL_ACKEN] = 1'b0;
                        s_nxt.irq_flag = 1'b1;
                        s_nxt.phase = i2c_arb_pkg::ST_IDLE;
                    end else if (s_r.bit_cnt == 4'h8) begin
                        s_nxt.ackstat = sda_s;
                        s_nxt.bf = 1'b0;
                        s_nxt.irq_flag = 1'b1;
                        s_nxt.sda_drive_low = 1'b0;
                        s_nxt.phase = i2c_arb_pkg::ST_IDLE;
                    end else begin
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                        s_nxt.shift = {s_r.shift[6:0], 1'b1};
                        s_nxt.sda_drive_low = (s_r.bit_cnt == 4'h7) ? 1'b0 : ~s_r.shift[6];
                        s_nxt.phase = i2c_arb_pkg::ST_TX_LOW;
                    end
                end
            end
            // Stop: SDA low first, then SCL released
            i2c_arb_pkg::ST_P_LOW: begin
                if (brg_zero && !sda_s) begin
                    s_nxt.scl_drive_low = 1'b0;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_P_HIGH;
                end
            end
            // SCL high for one count, then SDA released
            i2c_arb_pkg::ST_P_HIGH: begin
                if (brg_zero && scl_s) begin
                    s_nxt.sda_drive_low = 1'b0;
                    s_nxt.baud_generator = brg_load(s_r.reload);
                    s_nxt.phase = i2c_arb_pkg::ST_P_DONE;
                end
            end
            // Stop complete once SDA reads high
            i2c_arb_pkg::ST_P_DONE: begin
                if (brg_zero && sda_s) begin
                    s_nxt.ctrl[`CTRL_PEN] = 1'b0;
                    s_nxt.irq_flag = 1'b1;
                    s_nxt.phase = i2c_arb_pkg::ST_IDLE;
                end
            end
            // Unused codes fall back to idle
            default: begin
                s_nxt.phase = i2c_arb_pkg::ST_IDLE;
            end
        endcase
        // Lost arbitration in any phase: free lines and go idle
        if (coll) begin
            s_nxt.bcol = 1'b1;
            s_nxt.bf = 1'b0;
            s_nxt.sda_drive_low = 1'b0;
            s_nxt.scl_drive_low = 1'b0;
            s_nxt.ctrl[`CTRL_SEN] = 1'b0;
            s_nxt.ctrl[`CTRL_RSEN] = 1'b0;
            s_nxt.ctrl[`CTRL_PEN] = 1'b0;
            s_nxt.ctrl[`CTRL_ACKEN] = 1'b0;
            s_nxt.phase = i2c_arb_pkg::ST_IDLE;
        end
        // Register writes; hardware sets in the same cycle win over clears, except an IF set while IF is already 1
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL: begin
                    // Several enables may be set; idle takes one at a time
                    s_nxt.ctrl = reg_wdata[6:0];
                end
                `ADDR_STAT: begin
                    // Write 0 clears; a set from hardware this cycle is kept, except for IF when IF was already 1
                    if (!reg_wdata[`STAT_WRITE_COLLISION_FLAG]) begin
                        s_nxt.write_collision_flag = 1'b0;
                    end
                    if (!reg_wdata[`STAT_BCOL] && !coll) begin
                        s_nxt.bcol = 1'b0;
                    end
                    if (!reg_wdata[`STAT_IF] && s_nxt.irq_flag == s_r.irq_flag) begin
                        s_nxt.irq_flag = 1'b0;
                    end
                end
                `ADDR_BUF: begin
                    if (s_r.phase != i2c_arb_pkg::ST_IDLE || seq_busy(s_r.ctrl)
                        || s_r.bf) begin
                        s_nxt.write_collision_flag = 1'b1;
                    end else begin
                        s_nxt.buffer = reg_wdata;
                        s_nxt.shift = reg_wdata;
                        s_nxt.bf = 1'b1;
                    end
                end
                `ADDR_RELOAD: begin
                    s_nxt.reload = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        // Port disabled: no transfer runs, bus status is forgotten
        if (!en) begin
            s_nxt.start_seen = 1'b0;
            s_nxt.stop_seen = 1'b0;
            s_nxt.phase = i2c_arb_pkg::ST_IDLE;
            s_nxt.sda_drive_low = 1'b0;
            s_nxt.scl_drive_low = 1'b0;
            s_nxt.bf = 1'b0;
        end
        // Read data valid the cycle after the strobe only
        s_nxt.rd_data = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: s_nxt.rd_data = {1'b0, s_r.ctrl};
                `ADDR_STAT: s_nxt.rd_data = {
                    (s_r.phase != i2c_arb_pkg::ST_IDLE) | seq_busy(s_r.ctrl),
                    s_r.ackstat, s_r.irq_flag, s_r.bcol, s_r.write_collision_flag,
                    s_r.stop_seen, s_r.start_seen, s_r.bf};
                `ADDR_BUF: s_nxt.rd_data = s_r.buffer;
                `ADDR_RELOAD: s_nxt.rd_data = s_r.reload;
                default: s_nxt.rd_data = 8'h00;
            endcase
        end
    end

    // Single state register; reset disables the port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.reload <= `RELOAD_RST;
            s_r.sda_sync <= 2'h3;
            s_r.scl_sync <= 2'h3;
            s_r.sda_prev <= 1'b1;
            s_r.scl_prev <= 1'b1;
            s_r.phase <= i2c_arb_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops; enable low means driving
    assign reg_rdata = s_r.rd_data;
    assign wake_req = s_r.wake;
    // Pins only ever pull low; the pull-ups make the high level
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe_n = ~s_r.sda_drive_low;
    assign scl_oe_n = ~s_r.scl_drive_low;
endmodule : i2c_master_bus_arbitration

// [tb/i2c_arb_asserts.sv]
// Port-level checker for the I2C arbitration block
`timescale 1ns/1ps
module i2c_arb_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic slave_event,
    input wire logic wake_req,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Master pulls SDA while its own SCL is released: Start or Restart hold
    sequence s_sda_grab;
        $fell(sda_oe_n) && scl_oe_n;
    endsequence
    // SCL held low by someone else while the master drives neither line
    sequence s_scl_low_free;
        (sda_oe_n && scl_oe_n && !scl_in) [*4];
    endsequence
    a_reset_frees_lines:
        assert property (disable iff (1'b0) sys_rst |=> sda_oe_n && scl_oe_n)
        else $error("Lines held after reset");
    a_reset_quiet_out:
        assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00 && !wake_req)
        else $error("Outputs active after reset");
    a_rdata_only_read:
        assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data without a read");
    a_wake_needs_sleep:
        assert property (wake_req |-> $past(sleep_mode) && $past(slave_event))
        else $error("Wake without sleeping slave event");
    a_grab_holds_scl:
        assert property (s_sda_grab |=> scl_oe_n [*3])
        else $error("SCL pulled too soon after SDA");
    a_grab_ends_scl:
        assert property (s_sda_grab |-> ##[1:600] (!scl_oe_n || sda_oe_n))
        else $error("Start hold never finished");
    a_scl_low_no_sda:
        assert property (s_scl_low_free |=> sda_oe_n)
        else $error("SDA pulled while SCL held low");
    a_pins_open_drain:
        assert property (sda_out == 1'b0 && scl_out == 1'b0)
        else $error("Pin drives a high level");
endmodule : i2c_arb_asserts
bind i2c_master_bus_arbitration i2c_arb_asserts i2c_arb_asserts_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .slave_event(slave_event), .wake_req(wake_req), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n));

// [tb/i2c_peer_model.sv]
// Another party on the shared open-drain SDA and SCL lines
`timescale 1ns/1ps
module i2c_peer_model (
    input wire logic sda_oe_n,
    input wire logic scl_oe_n,
    input wire logic sda_pull_low,
    input wire logic clk_run,
    output logic sda_in,
    output logic scl_in
);
    logic scl_phase = 1'b1;
    // Peer clock of 160 ns, parked high outside its frames
    always #80 scl_phase = clk_run ? ~scl_phase : 1'b1;
    // Pull-ups win only where no party pulls; peer pulls only when told
    assign sda_in = sda_oe_n & ~sda_pull_low;
    assign scl_in = scl_oe_n & scl_phase;
endmodule : i2c_peer_model

// [tb/test_i2c_master_bus_arbitration.sv]
// Self-checking bench for the I2C arbitration block
`timescale 1ns/1ps
`include "i2c_arb_params.svh"
module test_i2c_master_bus_arbitration;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_mode = 1'b0;
    logic slave_event = 1'b0;
    logic peer_sda_low = 1'b0;
    logic peer_clk_run = 1'b0;
    logic [7:0] reg_rdata;
    logic wake_req, sda_in, sda_out, sda_oe_n, scl_in, scl_out, scl_oe_n;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] rd_val;
    logic [7:0] tx_byte;
    always #4 clk_sys = ~clk_sys;
    i2c_master_bus_arbitration i2c_master_bus_arbitration_inst (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .slave_event(slave_event), .wake_req(wake_req), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n));
    i2c_peer_model i2c_peer_model_inst (.sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
        .sda_pull_low(peer_sda_low), .clk_run(peer_clk_run), .sda_in(sda_in),
        .scl_in(scl_in));
    // Enabled control word with interrupts on and at most one sequence bit
    function automatic logic [7:0] ctrl(input int bit_idx);
        ctrl = 8'h00;
        ctrl[`CTRL_EN] = 1'b1;
        ctrl[`CTRL_IE] = 1'b1;
        if (bit_idx >= 0) ctrl[bit_idx] = 1'b1;
    endfunction : ctrl
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t register %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit %b, expected %b", $time, got, exp);
        end
    endtask : chk_pin
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd
    // Bounded poll of one status bit
    task automatic wait_stat(input int b);
        rd_val = 8'h00;
        for (int i = 0; i < 2000 && rd_val[b] !== 1'b1; i++) rd(`ADDR_STAT, rd_val);
        chk_pin(rd_val[b], 1'b1);
    endtask : wait_stat
    // Next moment the master releases SCL for a high phase
    task automatic next_high;
        for (int i = 0; i < 400 && scl_oe_n !== 1'b0; i++) @(negedge clk_sys);
        for (int i = 0; i < 400 && scl_oe_n !== 1'b1; i++) @(negedge clk_sys);
    endtask : next_high
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // Hang guard, well above the length of the sequence
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        rd_val = $urandom(26314);
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`ADDR_STAT, rd_val);
        chk_reg(rd_val, 8'h00);
        rd(`ADDR_RELOAD, rd_val);
        chk_reg(rd_val, `RELOAD_RST);
        rd(4'hF, rd_val);
        chk_reg(rd_val, 8'h00);
        wr(`ADDR_CTRL, ctrl(-1));
        wr(`ADDR_RELOAD, 8'h18 + 8'($urandom % 8));
        // Slave events wake the core only while it sleeps
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys);
            sleep_mode <= s[0];
            slave_event <= 1'b1;
            @(posedge clk_sys);
            slave_event <= 1'b0;
            @(negedge clk_sys);
            chk_pin(wake_req, s[0]);
        end
        sleep_mode <= 1'b0;
        // Start on a free bus, then lose the first bit to another master
        wr(`ADDR_CTRL, ctrl(`CTRL_SEN));
        wait_stat(`STAT_IF);
        chk_pin(rd_val[`STAT_BCOL], 1'b0);
        wr(`ADDR_STAT, 8'h00);
        tx_byte = 8'h80 | 8'($urandom);
        wr(`ADDR_BUF, tx_byte);
        next_high();
        @(posedge clk_sys);
        peer_sda_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_pin(sda_oe_n & scl_oe_n, 1'b1);
        rd(`ADDR_STAT, rd_val);
        chk_pin(rd_val[`STAT_BCOL], 1'b1);
        chk_pin(rd_val[`STAT_BF], 1'b0);
        // Peer lets SDA rise with SCL high: a Stop on the bus
        peer_sda_low <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(`ADDR_STAT, rd_val);
        chk_pin(rd_val[`STAT_IF], 1'b1);
        chk_pin(rd_val[`STAT_STOP], 1'b1);
        chk_pin(rd_val[`STAT_BCOL], 1'b1);
        wr(`ADDR_STAT, 8'h00);
        rd(`ADDR_STAT, rd_val);
        chk_pin(rd_val[`STAT_BCOL], 1'b0);
        // Fresh byte starts at its first bit; a second write is refused
        tx_byte = 8'($urandom);
        wr(`ADDR_BUF, tx_byte);
        wr(`ADDR_BUF, ~tx_byte);
        for (int i = 7; i >= 0; i--) begin
            next_high();
            chk_pin(sda_oe_n, tx_byte[i]);
        end
        wait_stat(`STAT_IF);
        chk_pin(rd_val[`STAT_WRITE_COLLISION_FLAG], 1'b1);
        wr(`ADDR_STAT, 8'h00);
        // Buffer write during Stop is dropped
        wr(`ADDR_CTRL, ctrl(`CTRL_PEN));
        wr(`ADDR_BUF, tx_byte ^ 8'hA5);
        wait_stat(`STAT_IF);
        chk_pin(rd_val[`STAT_STOP], 1'b1);
        chk_pin(rd_val[`STAT_WRITE_COLLISION_FLAG], 1'b1);
        rd(`ADDR_BUF, rd_val);
        chk_reg(rd_val, tx_byte);
        // Disabling the port clears the bus flags
        wr(`ADDR_CTRL, 8'h00);
        rd(`ADDR_STAT, rd_val);
        chk_reg(rd_val & 8'h06, 8'h00);
        wr(`ADDR_CTRL, ctrl(-1));
        wr(`ADDR_STAT, 8'h00);
        // Another master pulls SDA during our Start count: no collision
        wr(`ADDR_CTRL, ctrl(`CTRL_SEN));
        repeat (4) @(posedge clk_sys);
        peer_sda_low <= 1'b1;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_pin(sda_oe_n, 1'b0);
        peer_sda_low <= 1'b0;
        wait_stat(`STAT_IF);
        chk_pin(rd_val[`STAT_BCOL], 1'b0);
        wr(`ADDR_STAT, 8'h00);
        // Repeated Start on a quiet bus completes cleanly
        wr(`ADDR_CTRL, ctrl(`CTRL_RSEN));
        wait_stat(`STAT_IF);
        chk_pin(rd_val[`STAT_BCOL], 1'b0);
        wr(`ADDR_STAT, 8'h00);
        wr(`ADDR_CTRL, ctrl(`CTRL_PEN));
        wait_stat(`STAT_IF);
        wr(`ADDR_STAT, 8'h00);
        // Peer clocks SCL while we try to Start
        peer_clk_run <= 1'b1;
        wr(`ADDR_CTRL, ctrl(`CTRL_SEN));
        wait_stat(`STAT_BCOL);
        rd(`ADDR_CTRL, rd_val);
        chk_reg(rd_val, ctrl(-1));
        chk_pin(sda_oe_n & scl_oe_n, 1'b1);
        peer_clk_run <= 1'b0;
        repeat (40) @(posedge clk_sys);
        // Reset in mid-byte frees the lines and disables the port
        wr(`ADDR_BUF, tx_byte);
        next_high();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        chk_pin(sda_oe_n & scl_oe_n, 1'b1);
        rd(`ADDR_CTRL, rd_val);
        chk_reg(rd_val, 8'h00);
        complete_run();
    end
endmodule : test_i2c_master_bus_arbitration
